// >>> include/frc_pkg.sv
`default_nettype none
package frc_pkg;
  localparam int unsigned CFG_W = 16;
  localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
  localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [15:0] RCR_ID_OFFSET = 16'h0005;
  localparam logic [15:0] RCR_RESET = 16'hbfcf;
  localparam logic [15:0] RCR_RSVD_MASK = 16'h4030;
  localparam int unsigned RM_BIT = 15;
  localparam int unsigned LC_LSB = 11;
  localparam int unsigned WT_BIT = 10;
  localparam int unsigned DH_BIT = 9;
  localparam int unsigned WC_BIT = 8;
  localparam int unsigned BO_BIT = 7;
  localparam int unsigned CE_BIT = 6;
  localparam int unsigned BW_BIT = 3;
  localparam int unsigned BL_LSB = 0;
  localparam logic [2:0] LC_CODE2 = 3'h2;
  localparam logic [2:0] LC_CODE5 = 3'h5;
  localparam logic [2:0] BL_4 = 3'h1;
  localparam logic [2:0] BL_8 = 3'h2;
  localparam logic [2:0] BL_16 = 3'h3;
  localparam logic [2:0] BL_CONT = 3'h7;
  localparam logic [4:0] PAGE_WORDS = 5'h04;
  typedef enum logic [1:0] {
    MODE_ARRAY = 2'b00,
    MODE_ID    = 2'b01,
    MODE_SETUP = 2'b10
  } frc_mode_e;
endpackage : frc_pkg
`default_nettype wire

// >>> src/frc_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Derives the effective read behaviour from the stored register
module frc_decode (
  input  wire logic [15:0] cfg,
  output logic             sync_burst,
  output logic [2:0]       latency,
  output logic             wait_high,
  output logic             hold_two,
  output logic             wait_early,
  output logic             rise_edge,
  output logic             no_wrap,
  output logic [4:0]       burst_words,
  output logic             burst_cont
);
  wire       async_mode = cfg[frc_pkg::RM_BIT];
  wire [2:0] bl         = cfg[frc_pkg::BL_LSB +: 3];
  wire [2:0] lc         = cfg[frc_pkg::LC_LSB +: 3];
  wire       lc_ok      = (lc >= frc_pkg::LC_CODE2) && (lc <= frc_pkg::LC_CODE5);
  assign sync_burst = ~async_mode;
  // Asynchronous mode masks every other field except WAIT polarity to a fixed value
  assign latency    = (async_mode || !lc_ok) ? 3'h0 : lc;
  assign wait_high  = cfg[frc_pkg::WT_BIT];
  assign hold_two   = async_mode ? 1'b0 : cfg[frc_pkg::DH_BIT];
  assign wait_early = async_mode ? 1'b0 : cfg[frc_pkg::WC_BIT];
  assign rise_edge  = async_mode ? 1'b1 : cfg[frc_pkg::CE_BIT];
  assign no_wrap    = async_mode ? 1'b1 : cfg[frc_pkg::BW_BIT];
  assign burst_cont = !async_mode && (bl == frc_pkg::BL_CONT);
  assign burst_words = async_mode ? frc_pkg::PAGE_WORDS :
                       (bl == frc_pkg::BL_4)  ? 5'h04 :
                       (bl == frc_pkg::BL_8)  ? 5'h08 :
                       (bl == frc_pkg::BL_16) ? 5'h10 : 5'h00;
endmodule : frc_decode
`default_nettype wire

// >>> src/frc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module frc_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic s1_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_q <= din;
      dout <= s1_q;
    end
  end
endmodule : frc_sync
`default_nettype wire

// >>> src/frc_top.sv
// Functional notes
// - Configuration set is two writes; value sits on address bits 15:0 both times.
// - Value latched on first rising edge of address-valid, chip-select or write strobe.
// - Command accepted whatever the programming supply level; no error raised.
// - After the command completes the device returns to read-array mode.
// - Identifier mode then reading word 05h returns the register contents.
// - Read-type field 0 selects synchronous burst, 1 asynchronous; default 1.
// - Asynchronous read type makes all other fields ignored; the WAIT polarity bit still applies here.
// - Latency codes 2 to 5 valid; 001 and 111 reserved; default 111.
// - First burst word comes latency clocks after address-valid deasserts.
// - WAIT polarity bit: 0 asserted low, 1 asserted high; default 1.
// - Output data invalid while WAIT asserted; host must not capture it.
// - Data-hold bit: 0 one clock, 1 two clocks per word; default 1.
// - WAIT timing bit: 0 during delay, 1 one data cycle early; default 1.
// - Burst-order bit 1 selects linear order, the only defined ordering.
// - Clock-edge bit: 0 falling edge, 1 rising edge; default 1.
// - Wrap bit: 0 wraps within burst length, 1 no wrap; default 1.
// - Burst length 001=4, 010=8, 011=16, 111=continuous; default 111.
// - Asynchronous page mode uses a fixed four-word page.
// - Status, query and identifier modes give only single reads, no bursts.
// - Read configuration applies alike to all partitions and block types.
`timescale 1ns/1ps
`default_nettype none
module frc_top (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        address_valid_n,
  input  wire logic        chip_select_n,
  input  wire logic        write_n,
  input  wire logic        output_enable_n,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  data_in,
  input  wire logic        vpp_low,
  output logic [15:0]      data_out,
  output logic             data_oe,
  output logic             wait_out,
  output logic             wait_oe,
  output logic [15:0]      read_config_reg,
  output logic             sync_burst_q,
  output logic [2:0]       latency_q,
  output logic             hold_two_q,
  output logic             wait_early_q,
  output logic             rise_edge_q,
  output logic             no_wrap_q,
  output logic [4:0]       burst_words_q,
  output logic             burst_cont_q,
  output logic             array_mode_q,
  output logic             first_word_q,
  output logic             cmd_error_q
);
  // Pins are asynchronous to this clock
  logic adv_s;
  logic ce_s;
  logic we_s;
  logic oe_s;
  logic vpp_s;
  logic [15:0] addr_s1_q;
  logic [15:0] addr_s_q;
  logic [7:0]  data_s1_q;
  logic [7:0]  data_s_q;

  frc_sync u_adv (.clock(clock), .rst(rst), .din(address_valid_n), .dout(adv_s));
  frc_sync u_ce  (.clock(clock), .rst(rst), .din(chip_select_n), .dout(ce_s));
  frc_sync u_we  (.clock(clock), .rst(rst), .din(write_n), .dout(we_s));
  frc_sync u_oe  (.clock(clock), .rst(rst), .din(output_enable_n), .dout(oe_s));
  // Supply level is synchronised but never gates the configuration command
  frc_sync u_vpp (.clock(clock), .rst(rst), .din(vpp_low), .dout(vpp_s));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_s1_q <= 16'h0000;
      addr_s_q  <= 16'h0000;
      data_s1_q <= 8'h00;
      data_s_q  <= 8'h00;
    end else begin
      addr_s1_q <= addr;
      addr_s_q  <= addr_s1_q;
      data_s1_q <= data_in;
      data_s_q  <= data_s1_q;
    end
  end

  // Previous synchronised strobe levels for edge detection
  logic adv_p_q;
  logic ce_p_q;
  logic we_p_q;
  logic [15:0] addr_p_q;
  logic [7:0]  data_p_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      adv_p_q  <= 1'b1;
      ce_p_q   <= 1'b1;
      we_p_q   <= 1'b1;
      addr_p_q <= 16'h0000;
      data_p_q <= 8'h00;
    end else begin
      adv_p_q  <= adv_s;
      ce_p_q   <= ce_s;
      we_p_q   <= we_s;
      addr_p_q <= addr_s_q;
      data_p_q <= data_s_q;
    end
  end

  // A write cycle ends at the first rising strobe edge; value sampled just before it
  wire cycle_open = ~ce_p_q & ~we_p_q;
  wire any_rise   = (adv_s & ~adv_p_q) | (ce_s & ~ce_p_q) | (we_s & ~we_p_q);
  wire wr_latch   = cycle_open & any_rise;
  wire [15:0] wr_value = addr_p_q;
  wire [7:0]  wr_cmd   = data_p_q;

  // Command state
  frc_pkg::frc_mode_e mode_q;
  frc_pkg::frc_mode_e mode_d;
  logic [15:0] pend_q;
  logic [15:0] cfg_q;
  logic [15:0] cfg_d;
  logic        err_d;

  wire is_setup   = wr_cmd == frc_pkg::CMD_CFG_SETUP;
  wire is_confirm = wr_cmd == frc_pkg::CMD_CFG_CONFIRM;
  wire is_read_id = wr_cmd == frc_pkg::CMD_READ_ID;
  wire is_read_ar = wr_cmd == frc_pkg::CMD_READ_ARRAY;

  // Second write of a pair either loads the register or is refused
  always_comb begin
    mode_d = mode_q;
    cfg_d  = cfg_q;
    err_d  = cmd_error_q;
    if (wr_latch) begin
      case (mode_q)
        frc_pkg::MODE_SETUP: begin
          // Supply level is deliberately not consulted here
          if (is_confirm) begin
            cfg_d = wr_value;
          end else begin
            err_d = 1'b1;
          end
          mode_d = frc_pkg::MODE_ARRAY;
        end
        default: begin
          if (is_setup) begin
            mode_d = frc_pkg::MODE_SETUP;
          end else if (is_read_id) begin
            mode_d = frc_pkg::MODE_ID;
          end else if (is_read_ar) begin
            mode_d = frc_pkg::MODE_ARRAY;
            err_d  = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= frc_pkg::MODE_ARRAY;
      cfg_q  <= frc_pkg::RCR_RESET;
      pend_q <= 16'h0000;
      cmd_error_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cfg_q  <= cfg_d;
      cmd_error_q <= err_d;
      if (wr_latch && is_setup && mode_q != frc_pkg::MODE_SETUP) begin
        pend_q <= wr_value;
      end
    end
  end

  // Effective configuration, shared by every partition
  logic       sync_burst;
  logic [2:0] latency;
  logic       wait_high;
  logic       hold_two;
  logic       wait_early;
  logic       rise_edge;
  logic       no_wrap;
  logic [4:0] burst_words;
  logic       burst_cont;
  frc_decode u_dec (
    .cfg        (cfg_q),
    .sync_burst (sync_burst),
    .latency    (latency),
    .wait_high  (wait_high),
    .hold_two   (hold_two),
    .wait_early (wait_early),
    .rise_edge  (rise_edge),
    .no_wrap    (no_wrap),
    .burst_words(burst_words),
    .burst_cont (burst_cont)
  );

  // Latency counter from address-valid deassertion to first word
  logic [2:0] lat_cnt_q;
  logic       lat_run_q;
  wire adv_rise  = adv_s & ~adv_p_q;
  // A read is chip select low with the write strobe high
  wire in_array  = mode_q == frc_pkg::MODE_ARRAY;
  wire read_act  = ~ce_s & we_s;
  wire lat_start = adv_rise & read_act & sync_burst & (latency != 3'h0);
  wire lat_done  = lat_run_q & (lat_cnt_q == 3'h1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lat_cnt_q <= 3'h0;
      lat_run_q <= 1'b0;
      first_word_q <= 1'b0;
    end else begin
      first_word_q <= lat_done;
      if (lat_start) begin
        lat_cnt_q <= latency;
        lat_run_q <= 1'b1;
      end else if (lat_done || ce_s) begin
        lat_run_q <= 1'b0;
      end else if (lat_run_q) begin
        lat_cnt_q <= lat_cnt_q - 3'h1;
      end
    end
  end

  // Data valid only once latency elapsed in synchronous array reads
  logic data_ready_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_ready_q <= 1'b0;
    end else if (lat_start || ce_s) begin
      data_ready_q <= 1'b0;
    end else if (lat_done && in_array) begin
      data_ready_q <= 1'b1;
    end
  end

  // WAIT: asserted unless valid synchronous array data is on the bus
  wire wait_asserted = ~(sync_burst & in_array & data_ready_q);
  wire wait_level    = wait_high ? wait_asserted : ~wait_asserted;

  // Identifier read of word 05h returns the register
  wire id_read = (mode_q == frc_pkg::MODE_ID) & (addr_s_q == frc_pkg::RCR_ID_OFFSET);
  wire rd_en   = ~ce_s & ~oe_s & we_s;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_out <= 16'h0000;
      data_oe  <= 1'b0;
    end else begin
      data_out <= id_read ? cfg_q : 16'h0000;
      data_oe  <= rd_en & (mode_q == frc_pkg::MODE_ID);
    end
  end

  // WAIT is driven only while the chip is selected
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_out <= 1'b0;
      wait_oe  <= 1'b0;
    end else begin
      wait_out <= wait_level;
      wait_oe  <= ~ce_s;
    end
  end

  // Outside read-array mode only single words are delivered
  wire [4:0] words_eff = in_array ? burst_words : 5'h01;
  wire       cont_eff  = burst_cont & in_array;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      read_config_reg <= frc_pkg::RCR_RESET;
      array_mode_q    <= 1'b1;
    end else begin
      read_config_reg <= cfg_q;
      array_mode_q    <= in_array;
    end
  end

  // Registered copies of the effective settings for the read path
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_burst_q  <= 1'b0;
      latency_q     <= 3'h0;
      hold_two_q    <= 1'b0;
      wait_early_q  <= 1'b0;
      rise_edge_q   <= 1'b1;
      no_wrap_q     <= 1'b1;
      burst_words_q <= frc_pkg::PAGE_WORDS;
      burst_cont_q  <= 1'b0;
    end else begin
      sync_burst_q  <= sync_burst;
      latency_q     <= latency;
      hold_two_q    <= hold_two;
      wait_early_q  <= wait_early;
      rise_edge_q   <= rise_edge;
      no_wrap_q     <= no_wrap;
      burst_words_q <= words_eff;
      burst_cont_q  <= cont_eff;
    end
  end

  // Burst order bit and reserved bits carry no function; only linear order exists
  wire unused_ok = &{1'b0, pend_q, vpp_s, cfg_q[frc_pkg::BO_BIT]};
endmodule : frc_top
`default_nettype wire

// >>> tb/frc_host.sv
`timescale 1ns/1ps
`default_nettype none
module frc_host (
  input  wire logic        clock,
  input  wire logic [15:0] data_out,
  output logic             address_valid_n,
  output logic             chip_select_n,
  output logic             write_n,
  output logic             output_enable_n,
  output logic [15:0]      addr,
  output logic [7:0]       data_in
);
  initial begin
    {address_valid_n, chip_select_n, write_n, output_enable_n} = 4'hf;
    addr = 16'h0000;
    data_in = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  // Address and data stay put until well after the strobes rise; the bus then shows garbage
  task automatic wr(input logic [7:0] cmd, input logic [15:0] val);
    addr = val;
    data_in = cmd;
    {address_valid_n, chip_select_n, write_n} = 3'h0;
    step(4);
    {address_valid_n, chip_select_n, write_n} = 3'h7;
    step(6);
    addr = ~val;
    data_in = ~cmd;
    step(1);
  endtask : wr
  // Read data is taken only at the end, long after any wait state
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    addr = a;
    {address_valid_n, chip_select_n, output_enable_n} = 3'h0;
    step(3);
    address_valid_n = 1'b1;
    step(11);
    d = data_out;
    {chip_select_n, output_enable_n} = 2'h3;
    addr = ~a;
    step(3);
  endtask : rd
endmodule : frc_host
`default_nettype wire

// >>> tb/frc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module frc_top_properties (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        address_valid_n,
  input wire logic        chip_select_n,
  input wire logic        write_n,
  input wire logic        wait_out,
  input wire logic        wait_oe,
  input wire logic [15:0] read_config_reg,
  input wire logic        sync_burst_q,
  input wire logic [2:0]  latency_q,
  input wire logic        hold_two_q,
  input wire logic        wait_early_q,
  input wire logic        rise_edge_q,
  input wire logic        no_wrap_q,
  input wire logic [4:0]  burst_words_q,
  input wire logic        burst_cont_q,
  input wire logic        array_mode_q,
  input wire logic        first_word_q
);
  logic [3:0] since_wr_q;
  // Cycles since the write strobe was last low, saturating
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      since_wr_q <= 4'hf;
    end else if (!write_n) begin
      since_wr_q <= 4'h0;
    end else if (since_wr_q != 4'hf) begin
      since_wr_q <= since_wr_q + 4'h1;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  reset_value_a: assert property ($fell(rst) |-> read_config_reg == frc_pkg::RCR_RESET)
    else $error("register not at reset value");
  async_ignore_a: assert property (
    read_config_reg[15] && $past(read_config_reg, 2) == read_config_reg |-> !sync_burst_q
    && latency_q == 3'h0 && !hold_two_q && !wait_early_q && rise_edge_q && no_wrap_q
    && burst_words_q == (array_mode_q ? frc_pkg::PAGE_WORDS : 5'h01) && !burst_cont_q)
    else $error("asynchronous mode fields not forced");
  sync_fields_a: assert property (
    !read_config_reg[15] && $past(read_config_reg, 2) == read_config_reg |-> sync_burst_q
    && latency_q == read_config_reg[13:11] && hold_two_q == read_config_reg[9]
    && wait_early_q == read_config_reg[8] && rise_edge_q == read_config_reg[6]
    && no_wrap_q == read_config_reg[3])
    else $error("burst fields do not follow register");
  burst_len_a: assert property (
    !read_config_reg[15] && $past(read_config_reg, 2) == read_config_reg
    |-> burst_cont_q == (array_mode_q && read_config_reg[2:0] == 3'h7)
    && (burst_cont_q
    || burst_words_q == (array_mode_q ? (5'h02 << read_config_reg[1:0]) : 5'h01)))
    else $error("burst length decode wrong");
  array_after_a: assert property ($changed(read_config_reg) |-> ##[0:4] array_mode_q)
    else $error("not back in read-array mode");
  update_gate_a: assert property ($changed(read_config_reg) |-> since_wr_q < 4'hc)
    else $error("register changed without a write");
  first_word_a: assert property (
    $rose(address_valid_n) && !chip_select_n && write_n && sync_burst_q && array_mode_q
    |-> ##[2:10] first_word_q)
    else $error("first word not signalled");
  wait_level_a: assert property (
    wait_oe && read_config_reg[15] && $past(read_config_reg, 2) == read_config_reg
    |-> wait_out == read_config_reg[10])
    else $error("wait level wrong in asynchronous mode");
endmodule : frc_top_properties
bind frc_top frc_top_properties u_frc_top_properties (
  .clock, .rst, .address_valid_n, .chip_select_n, .write_n, .wait_out, .wait_oe,
  .read_config_reg, .sync_burst_q, .latency_q, .hold_two_q, .wait_early_q, .rise_edge_q,
  .no_wrap_q, .burst_words_q, .burst_cont_q, .array_mode_q, .first_word_q
);
`default_nettype wire

// >>> tb/tb_flash_read_config_register.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_read_config_register;
  logic        clock, rst, vpp_low;
  logic        address_valid_n, chip_select_n, write_n, output_enable_n;
  logic [15:0] addr, data_out, read_config_reg, cfg, rd_q;
  logic [7:0]  data_in;
  logic        data_oe, wait_out, wait_oe, sync_burst_q, hold_two_q, wait_early_q;
  logic        rise_edge_q, no_wrap_q, burst_cont_q, array_mode_q, first_word_q, cmd_error_q;
  logic [2:0]  latency_q;
  logic [4:0]  burst_words_q;
  logic [15:0] corner [3] = '{16'h1081, 16'h2fcb, 16'h8000};
  int          fail_count, num_checks;
  frc_top u_frc_top (
    .clock, .rst, .address_valid_n, .chip_select_n, .write_n, .output_enable_n, .addr,
    .data_in, .vpp_low, .data_out, .data_oe, .wait_out, .wait_oe, .read_config_reg,
    .sync_burst_q, .latency_q, .hold_two_q, .wait_early_q, .rise_edge_q, .no_wrap_q,
    .burst_words_q, .burst_cont_q, .array_mode_q, .first_word_q, .cmd_error_q
  );
  frc_host u_frc_host (
    .clock, .data_out, .address_valid_n, .chip_select_n, .write_n, .output_enable_n,
    .addr, .data_in
  );
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  function automatic logic [13:0] exp_dec(input logic [15:0] c);
    if (c[15]) begin
      return {1'b0, 3'h0, 4'h3, 1'b0, 5'h04};
    end
    return {1'b1, c[13:11], c[9], c[8], c[6], c[3], c[2:0] == 3'h7,
            c[2:0] == 3'h7 ? 5'h00 : 5'h02 << c[1:0]};
  endfunction : exp_dec
  function automatic logic [15:0] rand_cfg();
    logic [15:0] c;
    c = 16'($urandom) & ~frc_pkg::RCR_RSVD_MASK;
    c[13:11] = 3'(2 + $urandom_range(3));
    c[2:0] = c[2] ? 3'h7 : 3'(1 + $urandom_range(2));
    c[9:8] = (c[13:11] == frc_pkg::LC_CODE2) ? 2'h0 : c[9:8];
    c[7] = 1'b1;
    return c;
  endfunction : rand_cfg
  task automatic check_cfg(input logic [15:0] c);
    chk("read_config_reg", c, read_config_reg);
    chk("decoded fields", {2'h0, exp_dec(c)}, {2'h0, sync_burst_q, latency_q, hold_two_q,
      wait_early_q, rise_edge_q, no_wrap_q, burst_cont_q, burst_cont_q ? 5'h00 : burst_words_q});
    chk("array_mode_q", 16'h0001, {15'h0, array_mode_q});
    chk("cmd_error_q", 16'h0000, {15'h0, cmd_error_q});
    u_frc_host.wr(frc_pkg::CMD_READ_ID, 16'h0000);
    u_frc_host.rd(frc_pkg::RCR_ID_OFFSET, rd_q);
    chk("id read", c, rd_q);
    u_frc_host.wr(frc_pkg::CMD_READ_ARRAY, 16'h0000);
    u_frc_host.rd(16'($urandom), rd_q);
  endtask : check_cfg
  initial begin
    #80000;
    fail_count++;
    complete_run();
  end
  initial begin
    {rst, vpp_low} = 2'h2;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(73730));
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    repeat (3) @(posedge clock);
    #1 cfg = frc_pkg::RCR_RESET;
    check_cfg(cfg);
    for (int i = 0; i < 10; i++) begin
      cfg = (i < 3) ? corner[i] : rand_cfg();
      vpp_low = 1'($urandom);
      u_frc_host.wr(frc_pkg::CMD_CFG_SETUP, cfg);
      u_frc_host.wr(frc_pkg::CMD_CFG_CONFIRM, cfg);
      check_cfg(cfg);
    end
    // Setup followed by another command must be refused
    u_frc_host.wr(frc_pkg::CMD_CFG_SETUP, ~cfg & ~frc_pkg::RCR_RSVD_MASK);
    u_frc_host.wr(frc_pkg::CMD_READ_ID, ~cfg);
    chk("read_config_reg", cfg, read_config_reg);
    chk("cmd_error_q", 16'h0001, {15'h0, cmd_error_q});
    u_frc_host.wr(frc_pkg::CMD_READ_ARRAY, 16'h0000);
    check_cfg(cfg);
    complete_run();
  end
endmodule : tb_flash_read_config_register
`default_nettype wire
